// ===== logic/imuic_pkg.sv
// shared constants and types of the interrupt enable and pin control block
package imuic_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_ENG_EN0 = 8'h50;
  localparam logic [7:0] ADDR_ENG_EN1 = 8'h51;
  localparam logic [7:0] ADDR_ENG_EN2 = 8'h52;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h53;
  localparam logic [7:0] ADDR_HOLD_MODE = 8'h54;
  localparam logic [7:0] ADDR_MAP0 = 8'h55;
  localparam logic [7:0] ADDR_MAP1 = 8'h56;
  localparam logic [7:0] ADDR_MAP2 = 8'h57;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ==========================================================
  // writable bits; reserved bits are held at zero
  localparam logic [7:0] EN0_MASK = 8'hF7;
  localparam logic [7:0] EN1_MASK = 8'h7F;
  localparam logic [7:0] EN2_MASK = 8'h0F;
  localparam logic [7:0] HOLD_MASK = 8'h3F;

  // ==========================================================
  // enable byte fields
  localparam int EN0_FLAT = 7;
  localparam int EN0_ORIENT = 6;
  localparam int EN0_STAP = 5;
  localparam int EN0_DTAP = 4;
  localparam int EN1_FWM = 6;
  localparam int EN1_FFULL = 5;
  localparam int EN1_DRDY = 4;
  localparam int EN1_LOWG = 3;
  localparam int EN2_STEP = 3;
  localparam logic [7:0] AXIS_MASK = 8'h07;

  // ==========================================================
  // pin control fields, pin b upper nibble, pin a lower nibble
  localparam int PB_OE = 7;
  localparam int PB_OD = 6;
  localparam int PB_LVL = 5;
  localparam int PB_EDGE = 4;
  localparam int PA_OE = 3;
  localparam int PA_OD = 2;
  localparam int PA_LVL = 1;
  localparam int PA_EDGE = 0;

  // ==========================================================
  // hold mode fields
  localparam int HM_IN_EN_B = 5;
  localparam int HM_IN_EN_A = 4;
  localparam logic [3:0] HOLD_NONE = 4'h0;
  localparam logic [3:0] HOLD_LATCH = 4'hF;

  // ==========================================================
  // map fields
  localparam int MAP1_A_DRDY = 7;
  localparam int MAP1_A_FFULL = 5;
  localparam int MAP1_B_DRDY = 3;
  localparam int MAP1_B_FFULL = 1;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int HOLD_BASE_NS = 312500;
  localparam int HOLD_BASE_CYC = HOLD_BASE_NS / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W = 28;

  // per pin hold sequence, gray along idle, active, hold
  typedef enum logic [1:0] {
    IMUIC_IDLE = 2'b00,
    IMUIC_ACT = 2'b01,
    IMUIC_HOLD = 2'b11
  } imuic_hold_e;

endpackage

// ===== logic/imuic_sync3.sv
// three stage synchroniser with agreement filter for a pin input
`timescale 1ns/100ps
module imuic_sync3 (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // pin
  input wire logic async_i,
  output logic level_o
);

  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
    logic q;
  } imuic_sync_s;

  imuic_sync_s s;
  imuic_sync_s next_s;

  // ==========================================================
  // f1 feeds only f2; a change counts once f2 and f3 agree
  always_comb
  begin
    next_s = s;
    next_s.f1 = async_i;
    next_s.f2 = s.f1;
    next_s.f3 = s.f2;
    if (s.f2 == s.f3)
    begin
      next_s.q = s.f3;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign level_o = s.q;

endmodule

// ===== logic/imuic_pin_drv.sv
// electrical driver of one interrupt pin
`timescale 1ns/100ps
module imuic_pin_drv (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // interrupt and setup
  input wire logic irq_i,
  input wire logic out_en_i,
  input wire logic open_drain_i,
  input wire logic active_high_i,
  input wire logic edge_sel_i,
  // pad
  output logic pad_o,
  output logic pad_oe_o
);

  typedef struct packed {
    logic irq_d;
    logic pad;
    logic oe;
  } imuic_drv_s;

  imuic_drv_s s;
  imuic_drv_s next_s;
  logic asserted;
  logic pad_level;

  // ==========================================================
  always_comb
  begin
    next_s = s;
    next_s.irq_d = irq_i;
    // edge mode gives a one cycle pulse per rising interrupt
    asserted = edge_sel_i ? (irq_i & ~s.irq_d) : irq_i;
    pad_level = active_high_i ? asserted : ~asserted;
    if (!out_en_i)
    begin
      next_s.pad = 1'b0;
      next_s.oe = 1'b0;
    end
    else if (open_drain_i)
    begin
      // open drain only pulls low; the high level comes from the pull-up
      next_s.pad = 1'b0;
      next_s.oe = ~pad_level;
    end
    else
    begin
      next_s.pad = pad_level;
      next_s.oe = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pad_o = s.pad;
  assign pad_oe_o = s.oe;

endmodule

// ===== logic/imuic_top.sv
// interrupt engine enables, pin mapping, hold modes and pin control
`timescale 1ns/100ps
//
// Contract
// - each detection engine runs and raises only while its enable bit is set.
// - enable byte 0: flat, orient, single tap, double tap, reserved, anymotion z/y/x.
// - byte 1: watermark, full, ready, low-g, high-g z/y/x; byte 2: step, nomotion z/y/x.
// - step interrupt enable never starts, stops or clears the step count.
// - one pin control byte; upper nibble second pin, lower nibble first pin.
// - second pin drives only while control bit 7 is set.
// - first pin drives only while control bit 3 is set.
// - bit 6 picks push-pull or open drain for the second pin.
// - bit 2 picks push-pull or open drain for the first pin.
// - bit 5 sets second pin active level for its interrupt output.
// - with second pin output off, its level bit qualifies the trigger input.
// - bit 1 sets first pin level, for output or for trigger input.
// - frame tagging from a pin ignores that pin's level setting.
// - bit 4 selects edge or level signalling for the second pin.
// - bit 0 selects edge or level signalling for the first pin.
// - an interrupt reaches a pin only when its mapping bit is one.
// - four bit hold mode: zero unlatched, all ones latched, others timed.
module imuic_top
  import imuic_pkg::*;
#(
  parameter int HOLD_BASE_CYCLES = HOLD_BASE_CYC
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // register port from the serial interface
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // detection engines
  input wire logic [23:0] evt_i,
  output logic [23:0] eng_en_o,
  // fifo tagging
  input wire logic fifo_tag_pin_a_enable_i,
  input wire logic fifo_tag_pin_b_enable_i,
  output logic fifo_tag_a_o,
  output logic fifo_tag_b_o,
  // first interrupt pin
  input wire logic first_irq_pin_i,
  output logic first_irq_pin_o,
  output logic first_irq_pin_oe_o,
  // second interrupt pin
  input wire logic second_irq_pin_i,
  output logic second_irq_pin_o,
  output logic second_irq_pin_oe_o,
  // power unit trigger
  output logic power_unit_trigger_o
);

  typedef struct packed {
    logic [7:0] en0;
    logic [7:0] en1;
    logic [7:0] en2;
    logic [7:0] pin_ctrl;
    logic [7:0] hold_mode;
    logic [7:0] map0;
    logic [7:0] map1;
    logic [7:0] map2;
    logic [7:0] rdata;
    imuic_hold_e [1:0] st;
    logic [1:0][HOLD_CNT_W-1:0] cnt;
    logic [1:0] irq;
    logic pmu_trig;
    logic tag_a;
    logic tag_b;
  } imuic_state_s;

  imuic_state_s s;
  imuic_state_s next_s;

  logic [23:0] ev;
  logic [7:0] phys;
  logic [2:0] data;
  logic [1:0] cond;
  logic [3:0] mode;
  logic clr_latch;
  logic lvl_a;
  logic lvl_b;
  logic hit_a;
  logic hit_b;

  // ==========================================================
  // helpers

  // hold time doubles per code step above one
  function automatic logic [HOLD_CNT_W-1:0] hold_cycles(input logic [3:0] code);
    logic [HOLD_CNT_W-1:0] base;
    base = HOLD_CNT_W'(HOLD_BASE_CYCLES);
    hold_cycles = base << (code - 4'h1);
  endfunction

  // gather mapped groups onto one pin
  function automatic logic route(input logic [7:0] ph, input logic [2:0] dt,
                                 input logic [7:0] map_ph, input logic [2:0] map_dt);
    route = (|(ph & map_ph)) | (|(dt & map_dt));
  endfunction

  // ==========================================================
  // pin input sampling

  imuic_sync3 u_sync_a (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(first_irq_pin_i),
    .level_o(lvl_a)
  );

  imuic_sync3 u_sync_b (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(second_irq_pin_i),
    .level_o(lvl_b)
  );

  // ==========================================================
  // engine gating and routing

  always_comb
  begin
    ev = evt_i & {s.en2, s.en1, s.en0};
    phys[7] = ev[EN0_FLAT];
    phys[6] = ev[EN0_ORIENT];
    phys[5] = ev[EN0_STAP];
    phys[4] = ev[EN0_DTAP];
    phys[3] = |(ev[23:16] & AXIS_MASK);
    phys[2] = |(ev[7:0] & AXIS_MASK);
    phys[1] = |(ev[15:8] & AXIS_MASK);
    // the step bit only gates its event; the counter has its own controls
    phys[0] = ev[8 + EN1_LOWG] | ev[16 + EN2_STEP];
    data[2] = ev[8 + EN1_DRDY];
    data[1] = ev[8 + EN1_FWM];
    data[0] = ev[8 + EN1_FFULL];
    cond[0] = route(phys, data, s.map0, s.map1[MAP1_A_DRDY:MAP1_A_FFULL]);
    cond[1] = route(phys, data, s.map2, s.map1[MAP1_B_DRDY:MAP1_B_FFULL]);
  end

  // ==========================================================
  // trigger input and frame tagging

  always_comb
  begin
    // a trigger input is only looked at while its output driver is off
    hit_a = ~s.pin_ctrl[PA_OE] & s.hold_mode[HM_IN_EN_A]
          & (s.pin_ctrl[PA_LVL] ? lvl_a : ~lvl_a);
    hit_b = ~s.pin_ctrl[PB_OE] & s.hold_mode[HM_IN_EN_B]
          & (s.pin_ctrl[PB_LVL] ? lvl_b : ~lvl_b);
  end

  // ==========================================================
  // next state

  always_comb
  begin
    next_s = s;
    mode = s.hold_mode[3:0];
    clr_latch = reg_wr_i && (reg_addr_i == ADDR_HOLD_MODE);

    // register writes, reserved bits forced to zero
    if (reg_wr_i)
    begin
      if (reg_addr_i == ADDR_ENG_EN0)
      begin
        next_s.en0 = reg_wdata_i & EN0_MASK;
      end
      else if (reg_addr_i == ADDR_ENG_EN1)
      begin
        next_s.en1 = reg_wdata_i & EN1_MASK;
      end
      else if (reg_addr_i == ADDR_ENG_EN2)
      begin
        next_s.en2 = reg_wdata_i & EN2_MASK;
      end
      else if (reg_addr_i == ADDR_PIN_CTRL)
      begin
        next_s.pin_ctrl = reg_wdata_i;
      end
      else if (reg_addr_i == ADDR_HOLD_MODE)
      begin
        next_s.hold_mode = reg_wdata_i & HOLD_MASK;
      end
      else if (reg_addr_i == ADDR_MAP0)
      begin
        next_s.map0 = reg_wdata_i;
      end
      else if (reg_addr_i == ADDR_MAP1)
      begin
        next_s.map1 = reg_wdata_i;
      end
      else if (reg_addr_i == ADDR_MAP2)
      begin
        next_s.map2 = reg_wdata_i;
      end
    end

    // register reads answer one cycle later
    if (reg_rd_i)
    begin
      if (reg_addr_i == ADDR_ENG_EN0)
      begin
        next_s.rdata = s.en0;
      end
      else if (reg_addr_i == ADDR_ENG_EN1)
      begin
        next_s.rdata = s.en1;
      end
      else if (reg_addr_i == ADDR_ENG_EN2)
      begin
        next_s.rdata = s.en2;
      end
      else if (reg_addr_i == ADDR_PIN_CTRL)
      begin
        next_s.rdata = s.pin_ctrl;
      end
      else if (reg_addr_i == ADDR_HOLD_MODE)
      begin
        next_s.rdata = s.hold_mode;
      end
      else if (reg_addr_i == ADDR_MAP0)
      begin
        next_s.rdata = s.map0;
      end
      else if (reg_addr_i == ADDR_MAP1)
      begin
        next_s.rdata = s.map1;
      end
      else if (reg_addr_i == ADDR_MAP2)
      begin
        next_s.rdata = s.map2;
      end
      else
      begin
        next_s.rdata = READ_UNMAPPED;
      end
    end

    // per pin hold sequence; a new condition always beats a clear
    for (int p = 0; p < 2; p++)
    begin
      case (s.st[p])
        IMUIC_IDLE:
        begin
          next_s.cnt[p] = '0;
          if (cond[p])
          begin
            next_s.st[p] = IMUIC_ACT;
          end
        end
        IMUIC_ACT:
        begin
          if (!cond[p])
          begin
            if (mode == HOLD_NONE)
            begin
              next_s.st[p] = IMUIC_IDLE;
            end
            else
            begin
              next_s.st[p] = IMUIC_HOLD;
              next_s.cnt[p] = hold_cycles(mode);
            end
          end
        end
        IMUIC_HOLD:
        begin
          if (cond[p])
          begin
            next_s.st[p] = IMUIC_ACT;
          end
          else if (mode == HOLD_NONE)
          begin
            next_s.st[p] = IMUIC_IDLE;
          end
          else if (mode == HOLD_LATCH)
          begin
            if (clr_latch)
            begin
              next_s.st[p] = IMUIC_IDLE;
            end
          end
          else if (s.cnt[p] <= HOLD_CNT_W'(1))
          begin
            next_s.st[p] = IMUIC_IDLE;
            next_s.cnt[p] = '0;
          end
          else
          begin
            next_s.cnt[p] = s.cnt[p] - HOLD_CNT_W'(1);
          end
        end
        default:
        begin
          next_s.st[p] = IMUIC_IDLE;
        end
      endcase
      next_s.irq[p] = (next_s.st[p] != IMUIC_IDLE);
    end

    next_s.pmu_trig = hit_a | hit_b;
    // tagging sees the raw pin level, whatever the polarity bit says
    next_s.tag_a = fifo_tag_pin_a_enable_i & s.hold_mode[HM_IN_EN_A] & lvl_a;
    next_s.tag_b = fifo_tag_pin_b_enable_i & s.hold_mode[HM_IN_EN_B] & lvl_b;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================================
  // pin drivers

  imuic_pin_drv u_drv_a (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .irq_i(s.irq[0]),
    .out_en_i(s.pin_ctrl[PA_OE]),
    .open_drain_i(s.pin_ctrl[PA_OD]),
    .active_high_i(s.pin_ctrl[PA_LVL]),
    .edge_sel_i(s.pin_ctrl[PA_EDGE]),
    .pad_o(first_irq_pin_o),
    .pad_oe_o(first_irq_pin_oe_o)
  );

  imuic_pin_drv u_drv_b (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .irq_i(s.irq[1]),
    .out_en_i(s.pin_ctrl[PB_OE]),
    .open_drain_i(s.pin_ctrl[PB_OD]),
    .active_high_i(s.pin_ctrl[PB_LVL]),
    .edge_sel_i(s.pin_ctrl[PB_EDGE]),
    .pad_o(second_irq_pin_o),
    .pad_oe_o(second_irq_pin_oe_o)
  );

  // ==========================================================
  // outputs

  assign reg_rdata_o = s.rdata;
  assign eng_en_o = {s.en2, s.en1, s.en0};
  assign fifo_tag_a_o = s.tag_a;
  assign fifo_tag_b_o = s.tag_b;
  assign power_unit_trigger_o = s.pmu_trig;

endmodule

// ===== dv/imuic_top_props.sv
// port assertions of the interrupt enable and pin control block
`timescale 1ns/100ps
module imuic_top_props
  import imuic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // engines and tagging
  input wire logic [23:0] eng_en_o,
  input wire logic fifo_tag_pin_a_enable_i,
  input wire logic fifo_tag_a_o,
  // pins
  input wire logic first_irq_pin_o,
  input wire logic first_irq_pin_oe_o,
  input wire logic second_irq_pin_o,
  input wire logic second_irq_pin_oe_o,
  input wire logic power_unit_trigger_o
);
  // ====
  // shadow of the pin control byte
  logic [7:0] pc;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pc <= 8'h00;
    else if (reg_wr_i && reg_addr_i == ADDR_PIN_CTRL)
      pc <= reg_wdata_i;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ====
  // assertions
  a_pin_b_quiet: assert property (!pc[PB_OE] && !$past(pc[PB_OE]) |-> !second_irq_pin_oe_o)
    else $error("second pin driven while disabled");
  a_pin_a_quiet: assert property (!pc[PA_OE] && !$past(pc[PA_OE]) |-> !first_irq_pin_oe_o)
    else $error("first pin driven while disabled");
  a_pin_b_drain: assert property ((pc[7:6] == 2'h3) && ($past(pc[7:6]) == 2'h3)
    && second_irq_pin_oe_o |-> !second_irq_pin_o) else $error("second pin drives high");
  a_pin_a_drain: assert property ((pc[3:2] == 2'h3) && ($past(pc[3:2]) == 2'h3)
    && first_irq_pin_oe_o |-> !first_irq_pin_o) else $error("first pin drives high");
  a_edge_pulse_once: assert property ((pc[3:0] == 4'hB) && ($past(pc[3:0]) == 4'hB)
    && $rose(first_irq_pin_o) |=> !first_irq_pin_o) else $error("edge pulse too long");
  a_en0_write: assert property (reg_wr_i && reg_addr_i == ADDR_ENG_EN0 |=>
    eng_en_o[7:0] == ($past(reg_wdata_i) & EN0_MASK)) else $error("enable byte 0 wrong");
  a_reserved_zero: assert property ((eng_en_o & 24'hF08008) == 24'h000000)
    else $error("reserved enable bit set");
  a_read_ctrl: assert property (reg_rd_i && reg_addr_i == ADDR_PIN_CTRL |=>
    reg_rdata_o == $past(pc)) else $error("pin control readback wrong");
  a_tag_gated: assert property (fifo_tag_a_o |-> $past(fifo_tag_pin_a_enable_i))
    else $error("tag without enable");
  a_trig_gated: assert property (pc[PB_OE] && pc[PA_OE] && $past(pc[PB_OE], 6)
    && $past(pc[PA_OE], 6) |-> !power_unit_trigger_o) else $error("trigger with outputs on");
  c_pin_a: cover property ($rose(first_irq_pin_o));
  c_pin_b: cover property ($rose(second_irq_pin_o));
  c_trigger: cover property ($rose(power_unit_trigger_o));
endmodule

bind imuic_top imuic_top_props u_props (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .eng_en_o(eng_en_o),
  .fifo_tag_pin_a_enable_i(fifo_tag_pin_a_enable_i), .fifo_tag_a_o(fifo_tag_a_o),
  .first_irq_pin_o(first_irq_pin_o), .first_irq_pin_oe_o(first_irq_pin_oe_o),
  .second_irq_pin_o(second_irq_pin_o), .second_irq_pin_oe_o(second_irq_pin_oe_o),
  .power_unit_trigger_o(power_unit_trigger_o));

// ===== dv/imuic_host_model.sv
// host side of the two interrupt pins: line resolution and interrupt sensing
`timescale 1ns/100ps
module imuic_host_model (
  // device pads
  input wire logic a_pad_i,
  input wire logic a_oe_i,
  input wire logic b_pad_i,
  input wire logic b_oe_i,
  // host drive while the device output is off, and expected level
  input wire logic a_drv_en_i,
  input wire logic a_drv_i,
  input wire logic a_act_high_i,
  input wire logic b_drv_en_i,
  input wire logic b_drv_i,
  input wire logic b_act_high_i,
  // resolved lines and interrupt as seen
  output logic a_wire_o,
  output logic b_wire_o,
  output logic a_seen_o,
  output logic b_seen_o
);
  // a released line is pulled up, so a stale level never survives
  assign a_wire_o = a_oe_i ? a_pad_i : (a_drv_en_i ? a_drv_i : 1'b1);
  assign b_wire_o = b_oe_i ? b_pad_i : (b_drv_en_i ? b_drv_i : 1'b1);
  assign a_seen_o = (a_wire_o == a_act_high_i);
  assign b_seen_o = (b_wire_o == b_act_high_i);
endmodule

// ===== dv/imu_interrupt_enable_and_pin_ctrl_tb.sv
// self-checking bench of the interrupt enable and pin control block
`timescale 1ns/100ps
module imu_interrupt_enable_and_pin_ctrl_tb;
  import imuic_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [23:0] evt_i = 24'h000000;
  logic tag_a_en = 1'b0;
  logic tag_b_en = 1'b0;
  logic a_drv_en = 1'b0;
  logic a_drv = 1'b0;
  logic b_drv_en = 1'b0;
  logic b_drv = 1'b0;
  logic lvl_a = 1'b1;
  logic lvl_b = 1'b1;
  logic [7:0] reg_rdata_o;
  logic [23:0] eng_en_o;
  logic tag_a;
  logic tag_b;
  logic pa;
  logic pa_oe;
  logic pb;
  logic pb_oe;
  logic trig;
  logic a_wire;
  logic b_wire;
  logic a_seen;
  logic b_seen;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  logic [23:0] ens [6] = '{24'h000080, 24'h000000, 24'h000008, 24'h001000, 24'h080000,
    24'h000004};
  logic [23:0] evs [6] = '{24'h000080, 24'h000080, 24'h000008, 24'h001000, 24'h080000,
    24'h000004};
  int eexp [6] = '{6, 0, 0, 6, 6, 6};
  // pin a: level high, level low, drain, edge, off
  logic [7:0] pcs [10] = '{8'h0A, 8'h08, 8'h0C, 8'h0B, 8'h00,
    8'hAA, 8'h8A, 8'hCA, 8'hBA, 8'h0A};
  int pexp [10] = '{6, 6, 6, 1, 0, 6, 6, 6, 1, 0};

  always #20 sys_clk_i = ~sys_clk_i;

  // ====
  // design and host
  imuic_top #(.HOLD_BASE_CYCLES(4)) dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .evt_i(evt_i), .eng_en_o(eng_en_o),
    .fifo_tag_pin_a_enable_i(tag_a_en), .fifo_tag_pin_b_enable_i(tag_b_en),
    .fifo_tag_a_o(tag_a), .fifo_tag_b_o(tag_b), .first_irq_pin_i(a_wire),
    .first_irq_pin_o(pa), .first_irq_pin_oe_o(pa_oe), .second_irq_pin_i(b_wire),
    .second_irq_pin_o(pb), .second_irq_pin_oe_o(pb_oe), .power_unit_trigger_o(trig));
  imuic_host_model host_u (.a_pad_i(pa), .a_oe_i(pa_oe), .b_pad_i(pb), .b_oe_i(pb_oe),
    .a_drv_en_i(a_drv_en), .a_drv_i(a_drv), .a_act_high_i(lvl_a), .b_drv_en_i(b_drv_en),
    .b_drv_i(b_drv), .b_act_high_i(lvl_b), .a_wire_o(a_wire), .b_wire_o(b_wire),
    .a_seen_o(a_seen), .b_seen_o(b_seen));

  // ====
  // tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_i = 1'b0;
    check("read", 24'(reg_rdata_o), 24'(exp));
  endtask
  // events high for six cycles; count cycles the host sees the pin active
  task automatic run(input logic [23:0] ev, input logic on_b, output int cnt);
    cnt = 0;
    repeat (3) @(negedge sys_clk_i);
    for (int i = 0; i < 14; i++)
    begin
      @(negedge sys_clk_i);
      if ((on_b ? b_seen : a_seen) === 1'b1)
        cnt++;
      evt_i = (i < 6) ? ev : 24'h000000;
    end
  endtask

  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  // ====
  // main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    for (int i = 0; i < 8; i++)
      rd(8'(ADDR_ENG_EN0 + i), RST_BYTE);
    check("pin oe", 24'({pa_oe, pb_oe}), 24'h000000);
    wr(ADDR_ENG_EN0, 8'hFF);
    wr(ADDR_ENG_EN1, 8'hFF);
    wr(ADDR_ENG_EN2, 8'hFF);
    rd(ADDR_ENG_EN0, 8'hF7);
    rd(ADDR_ENG_EN1, 8'h7F);
    rd(ADDR_ENG_EN2, 8'h0F);
    check("enables", eng_en_o, 24'h0F7FF7);
    wr(8'h60, 8'h5A);
    rd(8'h60, READ_UNMAPPED);
    wr(ADDR_PIN_CTRL, 8'hFF);
    rd(ADDR_PIN_CTRL, 8'hFF);
    wr(ADDR_MAP0, 8'hFF);
    wr(ADDR_MAP1, 8'hF0);
    wr(ADDR_PIN_CTRL, 8'h0A);
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_ENG_EN0, ens[i][7:0]);
      wr(ADDR_ENG_EN1, ens[i][15:8]);
      wr(ADDR_ENG_EN2, ens[i][23:16]);
      run(evs[i], 1'b0, n);
      check("engine", 24'(n), 24'(eexp[i]));
    end
    wr(ADDR_ENG_EN0, 8'h80);
    wr(ADDR_MAP0, 8'h00);
    run(24'h000080, 1'b0, n);
    check("unmapped", 24'(n), 24'h000000);
    wr(ADDR_MAP0, 8'h80);
    wr(ADDR_MAP2, 8'h80);
    for (int i = 0; i < 10; i++)
    begin
      wr(ADDR_PIN_CTRL, pcs[i]);
      lvl_a = pcs[i][PA_LVL];
      lvl_b = pcs[i][PB_LVL];
      run(24'h000080, i > 4, n);
      check("pin", 24'(n), 24'(pexp[i]));
    end
    wr(ADDR_PIN_CTRL, 8'h0A);
    lvl_a = 1'b1;
    wr(ADDR_HOLD_MODE, 8'h0F);
    run(24'h000080, 1'b0, n);
    check("latched", 24'(n), 24'h00000C);
    wr(ADDR_HOLD_MODE, 8'h00);
    repeat (4) @(negedge sys_clk_i);
    check("cleared", 24'(pa), 24'h000000);
    // shortest timed hold: six active cycles plus one base period of four
    wr(ADDR_HOLD_MODE, 8'h01);
    run(24'h000080, 1'b0, n);
    check("timed", 24'(n), 24'h00000A);
    wr(ADDR_PIN_CTRL, 8'h02);
    wr(ADDR_HOLD_MODE, 8'h10);
    tag_a_en = 1'b1;
    a_drv_en = 1'b1;
    a_drv = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    check("trigger", 24'(trig), 24'h000001);
    check("tag", 24'(tag_a), 24'h000001);
    wr(ADDR_PIN_CTRL, 8'h00);
    repeat (10) @(negedge sys_clk_i);
    check("trigger", 24'(trig), 24'h000000);
    check("tag", 24'(tag_a), 24'h000001);
    a_drv_en = 1'b0;
    wr(ADDR_PIN_CTRL, 8'h20);
    wr(ADDR_HOLD_MODE, 8'h20);
    b_drv_en = 1'b1;
    b_drv = 1'b1;
    tag_b_en = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    check("trigger", 24'(trig), 24'h000001);
    check("tag b", 24'(tag_b), 24'h000001);
    // flipping the level bit drops the trigger but not the raw-level tag
    wr(ADDR_PIN_CTRL, 8'h00);
    repeat (10) @(negedge sys_clk_i);
    check("trigger", 24'(trig), 24'h000000);
    check("tag b", 24'(tag_b), 24'h000001);
    wr(ADDR_PIN_CTRL, 8'h20);
    b_drv = 1'b0;
    repeat (10) @(negedge sys_clk_i);
    check("trigger", 24'(trig), 24'h000000);
    check("tag b", 24'(tag_b), 24'h000000);
    complete_run();
  end
endmodule
